// >>> design/dlwu_defines.svh
`ifndef DLWU_DEFINES_SVH
`define DLWU_DEFINES_SVH

// operation codes
`define DLWU_OP_DIV_WORD_MEM 8'h64
`define DLWU_OP_DIV_WORD_IMM 8'h74
`define DLWU_OP_DIV_HALF_MEM 8'h65
`define DLWU_OP_DIV_HALF_IMM 8'h75
`define DLWU_OP_FDIV_SINGLE 8'h66
`define DLWU_OP_FDIV_DOUBLE 8'h67
`define DLWU_OP_AND_MEM 8'hE0
`define DLWU_OP_OR_MEM 8'hE4
`define DLWU_OP_XOR_MEM 8'hE8
`define DLWU_OP_AND_IMM 8'hF0
`define DLWU_OP_OR_IMM 8'hF4
`define DLWU_OP_XOR_IMM 8'hF8

// field and datapath widths
`define DLWU_WORD_W 32
`define DLWU_HALF_W 16
`define DLWU_M_W 4
`define DLWU_N_W 12
`define DLWU_INDEX_ADD_W 24
`define DLWU_DIV_DVD_W 128
`define DLWU_DIV_DVS_W 64

// result code values {less, greater, equal}
`define DLWU_CODE_RESET 3'h0
`define DLWU_CODE_LESS 3'h4
`define DLWU_CODE_GREATER 3'h2
`define DLWU_CODE_EQUAL 3'h1

`endif

// >>> design/dlwu_pkg.sv
package dlwu_pkg;

  typedef enum logic [4:0] {
    DLWU_K_NONE = 5'h01,
    DLWU_K_WDIV = 5'h02,
    DLWU_K_HDIV = 5'h04,
    DLWU_K_FDIV = 5'h08,
    DLWU_K_LOGIC = 5'h10
  } dlwu_kind_t;

  typedef enum logic [2:0] {
    DLWU_ST_IDLE = 3'h1,
    DLWU_ST_DIV = 3'h2,
    DLWU_ST_FIN = 3'h4
  } dlwu_state_t;

  typedef enum logic [1:0] {
    DLWU_LG_AND = 2'h0,
    DLWU_LG_OR = 2'h1,
    DLWU_LG_XOR = 2'h2
  } dlwu_logic_t;

endpackage : dlwu_pkg

// >>> design/dlwu_divider.sv
`timescale 1ns/1ps
module dlwu_divider #(
  parameter int DVD_W = 128,
  parameter int DVS_W = 64
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [DVD_W-1:0] dividend_i,
  input wire logic [DVS_W-1:0] divisor_i,
  output logic done_o,
  output logic [DVD_W-1:0] quotient_o
);
  localparam int CNT_W = $clog2(DVD_W + 1);

  logic [DVS_W:0] rem;
  logic [DVS_W-1:0] dvs;
  logic [CNT_W-1:0] cnt;
  logic busy;
  logic [DVS_W:0] trial;
  logic fits;

  initial begin
    if (DVS_W < 2 || DVS_W > DVD_W) begin
      $error("dlwu_divider: divisor width must lie between 2 and the dividend width");
    end
  end

  assign trial = {rem[DVS_W-1:0], quotient_o[DVD_W-1]};
  assign fits = trial >= {1'b0, dvs};

  // one quotient bit per cycle: small area, DVD_W cycles of latency
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rem <= '0;
      dvs <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done_o <= 1'b0;
      quotient_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy) begin
        rem <= '0;
        dvs <= divisor_i;
        quotient_o <= dividend_i;
        cnt <= CNT_W'(DVD_W);
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? trial - {1'b0, dvs} : trial;
        quotient_o <= {quotient_o[DVD_W-2:0], fits};
        cnt <= cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule : dlwu_divider

// >>> design/dlwu_unit.sv
`timescale 1ns/1ps
`include "dlwu_defines.svh"
module dlwu_unit #(
  parameter int EXP_W = 7,
  parameter int EXP_BIAS = 64
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [7:0] op_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic [31:0] reg_val_i,
  input wire logic [31:0] reg_pair_val_i,
  input wire logic [63:0] operand_i,
  input wire logic [`DLWU_M_W-1:0] m_field_i,
  input wire logic [`DLWU_N_W-1:0] n_field_i,
  input wire logic [3:0] index_field_i,
  input wire logic [31:0] index_val_i,
  output logic busy_o,
  output logic done_o,
  output logic wr_o,
  output logic wr_pair_o,
  output logic [31:0] res_o,
  output logic [31:0] res_pair_o,
  output logic result_less_flag_o,
  output logic result_greater_flag_o,
  output logic outcome_equal_flag_o,
  output logic fx_overflow_o,
  output logic divide_check_o,
  output logic exp_overflow_o,
  output logic exp_underflow_o,
  output logic spec_error_o
);
  localparam int DVD_W = `DLWU_DIV_DVD_W;
  localparam int DVS_W = `DLWU_DIV_DVS_W;
  localparam int FS_W = 31 - EXP_W;
  localparam int FD_W = 63 - EXP_W;
  localparam int EW = EXP_W + 3;
  initial begin
    if (EXP_W < 2 || EXP_W > 16 || EXP_BIAS >= (1 << EXP_W)) begin
      $error("dlwu_unit: exponent width or bias out of range");
    end
  end
  dlwu_pkg::dlwu_state_t state;
  dlwu_pkg::dlwu_kind_t kind, kind_q;
  dlwu_pkg::dlwu_logic_t lg_op;
  logic is_imm_logic, div_start, div_done, fdbl, fsign;
  logic neg_q, odd_q, dbl_q, dvs_zero_q, dvd_zero_q;
  logic q_ovf, q_top, f_ovf, f_unf;
  logic [31:0] logic_imm, logic_b, logic_res;
  logic [63:0] s_dvd, s_dvs, mag_dvd, mag_dvs, fa, fb, qs, frac, fres;
  logic [DVD_W-1:0] div_dvd, qmag, lim;
  logic [DVS_W-1:0] div_dvs;
  logic [EXP_W-1:0] ea, eb;
  logic [15:0] keep_lo_q;
  logic signed [EW-1:0] exp_q, exp_n;
  function automatic logic [2:0] arith_code(input logic nz, input logic neg);
    if (!nz) begin
      arith_code = `DLWU_CODE_EQUAL;
    end else if (neg) begin
      arith_code = `DLWU_CODE_LESS;
    end else begin
      arith_code = `DLWU_CODE_GREATER;
    end
  endfunction : arith_code
  function automatic logic [63:0] sext32(input logic [31:0] v);
    sext32 = {{32{v[31]}}, v};
  endfunction : sext32
  // decode of the requested operation
  always_comb begin
    kind = dlwu_pkg::DLWU_K_NONE;
    lg_op = dlwu_pkg::DLWU_LG_AND;
    is_imm_logic = 1'b0;
    case (op_i)
      `DLWU_OP_DIV_WORD_MEM, `DLWU_OP_DIV_WORD_IMM: begin
        kind = dlwu_pkg::DLWU_K_WDIV;
      end
      `DLWU_OP_DIV_HALF_MEM, `DLWU_OP_DIV_HALF_IMM: begin
        kind = dlwu_pkg::DLWU_K_HDIV;
      end
      `DLWU_OP_FDIV_SINGLE, `DLWU_OP_FDIV_DOUBLE: begin
        kind = dlwu_pkg::DLWU_K_FDIV;
      end
      `DLWU_OP_AND_MEM: begin
        kind = dlwu_pkg::DLWU_K_LOGIC;
      end
      `DLWU_OP_OR_MEM: begin
        kind = dlwu_pkg::DLWU_K_LOGIC;
        lg_op = dlwu_pkg::DLWU_LG_OR;
      end
      `DLWU_OP_XOR_MEM: begin
        kind = dlwu_pkg::DLWU_K_LOGIC;
        lg_op = dlwu_pkg::DLWU_LG_XOR;
      end
      `DLWU_OP_AND_IMM: begin
        kind = dlwu_pkg::DLWU_K_LOGIC;
        is_imm_logic = 1'b1;
      end
      `DLWU_OP_OR_IMM: begin
        kind = dlwu_pkg::DLWU_K_LOGIC;
        lg_op = dlwu_pkg::DLWU_LG_OR;
        is_imm_logic = 1'b1;
      end
      `DLWU_OP_XOR_IMM: begin
        kind = dlwu_pkg::DLWU_K_LOGIC;
        lg_op = dlwu_pkg::DLWU_LG_XOR;
        is_imm_logic = 1'b1;
      end
      default: begin
        kind = dlwu_pkg::DLWU_K_NONE;
      end
    endcase
  end
  // immediate built from M and N fields
  // index bits added only when index field nonzero
  assign logic_imm = {16'h0000, m_field_i, n_field_i}
    + ((index_field_i != 4'h0) ? {8'h00, index_val_i[`DLWU_INDEX_ADD_W-1:0]} : 32'h0000_0000);
  assign logic_b = is_imm_logic ? logic_imm : operand_i[31:0];
  // bitwise combine over the full word
  // same path serves the immediate forms
  always_comb begin
    case (lg_op)
      dlwu_pkg::DLWU_LG_OR: logic_res = reg_val_i | logic_b;
      dlwu_pkg::DLWU_LG_XOR: logic_res = reg_val_i ^ logic_b;
      default: logic_res = reg_val_i & logic_b;
    endcase
  end
  // divide operands: signs stripped here, restored on completion
  always_comb begin
    // pair dividend on even select, single register on odd
    s_dvd = reg_sel_i[0] ? sext32(reg_val_i) : {reg_val_i, reg_pair_val_i};
    s_dvs = sext32(operand_i[31:0]);
    // immediate divisor arrives on the same operand port
    if (kind == dlwu_pkg::DLWU_K_HDIV) begin
      s_dvd = sext32(reg_val_i);
      s_dvs = {{48{operand_i[15]}}, operand_i[15:0]};
    end
    mag_dvd = s_dvd[63] ? 64'h0 - s_dvd : s_dvd;
    mag_dvs = s_dvs[63] ? 64'h0 - s_dvs : s_dvs;
  end
  // float fields: sign, biased exponent, normalized fraction
  assign fdbl = op_i[0];
  // high word carries only FD_W-32 fraction bits below the exponent
  assign fa = fdbl ? {{(EXP_W + 1){1'b0}}, reg_val_i[FD_W-33:0], reg_pair_val_i}
    : {{(64 - FS_W){1'b0}}, reg_val_i[FS_W-1:0]};
  assign fb = fdbl ? {{(EXP_W + 1){1'b0}}, operand_i[FD_W-1:0]}
    : {{(64 - FS_W){1'b0}}, operand_i[FS_W-1:0]};
  assign ea = reg_val_i[30:31-EXP_W];
  assign eb = fdbl ? operand_i[62:63-EXP_W] : operand_i[30:31-EXP_W];
  assign fsign = reg_val_i[31] ^ (fdbl ? operand_i[63] : operand_i[31]);

  always_comb begin
    if (kind == dlwu_pkg::DLWU_K_FDIV) begin
      div_dvd = fdbl ? {64'h0, fa} << FD_W : {64'h0, fa} << FS_W;
      div_dvs = fb;
    end else begin
      div_dvd = {64'h0, mag_dvd};
      div_dvs = mag_dvs;
    end
  end

  assign div_start = (state == dlwu_pkg::DLWU_ST_IDLE) && start_i
    && (kind != dlwu_pkg::DLWU_K_LOGIC) && (kind != dlwu_pkg::DLWU_K_NONE)
    && !(kind == dlwu_pkg::DLWU_K_FDIV && fdbl && reg_sel_i[0]);

  dlwu_divider #(
    .DVD_W(DVD_W),
    .DVS_W(DVS_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(div_start),
    .dividend_i(div_dvd),
    .divisor_i(div_dvs),
    .done_o(div_done),
    .quotient_o(qmag)
  );

  // completion arithmetic for fixed point quotients
  always_comb begin
    qs = neg_q ? 64'h0 - qmag[63:0] : qmag[63:0];
    lim = (kind_q == dlwu_pkg::DLWU_K_HDIV) ? DVD_W'(1) << 15 : DVD_W'(1) << 31;
    q_ovf = neg_q ? (qmag > lim) : (qmag >= lim);
  end

  // completion arithmetic for float quotients
  always_comb begin
    q_top = dbl_q ? qmag[FD_W] : qmag[FS_W];
    if (q_top) begin
      frac = qmag[64:1];
      exp_n = exp_q + EW'(1);
    end else begin
      frac = qmag[63:0];
      exp_n = exp_q;
    end
    f_ovf = dvs_zero_q || (exp_n > EW'((1 << EXP_W) - 1));
    f_unf = !dvs_zero_q && !dvd_zero_q && (exp_n < EW'(0));
    if (dvd_zero_q || f_unf) begin
      fres = 64'h0;
    end else if (dbl_q) begin
      fres = {neg_q, exp_n[EXP_W-1:0], frac[FD_W-1:0]};
    end else begin
      fres = {neg_q, exp_n[EXP_W-1:0], frac[FS_W-1:0], 32'h0000_0000};
    end
  end

  // operation context held while the divider runs
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      kind_q <= dlwu_pkg::DLWU_K_NONE;
      neg_q <= 1'b0;
      odd_q <= 1'b0;
      dbl_q <= 1'b0;
      dvs_zero_q <= 1'b0;
      dvd_zero_q <= 1'b0;
      keep_lo_q <= 16'h0000;
      exp_q <= '0;
    end else if (div_start) begin
      kind_q <= kind;
      odd_q <= reg_sel_i[0];
      dbl_q <= fdbl;
      keep_lo_q <= reg_val_i[15:0];
      if (kind == dlwu_pkg::DLWU_K_FDIV) begin
        neg_q <= fsign;
        dvs_zero_q <= fb == 64'h0;
        dvd_zero_q <= fa == 64'h0;
        // fraction ratio below one keeps this exponent, the upper half adds one
        exp_q <= EW'(ea) - EW'(eb) + EW'(EXP_BIAS);
      end else begin
        neg_q <= s_dvd[63] ^ s_dvs[63];
        dvs_zero_q <= mag_dvs == 64'h0;
        dvd_zero_q <= mag_dvd == 64'h0;
        exp_q <= '0;
      end
    end
  end

  // sequencing: logic ops finish next cycle, divides wait on the divider
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= dlwu_pkg::DLWU_ST_IDLE;
      busy_o <= 1'b0;
    end else begin
      case (state)
        dlwu_pkg::DLWU_ST_IDLE: begin
          if (div_start) begin
            state <= dlwu_pkg::DLWU_ST_DIV;
            busy_o <= 1'b1;
          end
        end
        dlwu_pkg::DLWU_ST_DIV: begin
          if (div_done) begin
            state <= dlwu_pkg::DLWU_ST_FIN;
            busy_o <= 1'b0;
          end
        end
        dlwu_pkg::DLWU_ST_FIN: begin
          state <= dlwu_pkg::DLWU_ST_IDLE;
        end
        default: begin
          state <= dlwu_pkg::DLWU_ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // results, result code and exceptions leave together
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      wr_o <= 1'b0;
      wr_pair_o <= 1'b0;
      res_o <= 32'h0000_0000;
      res_pair_o <= 32'h0000_0000;
      {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o} <= `DLWU_CODE_RESET;
      {fx_overflow_o, divide_check_o, exp_overflow_o, exp_underflow_o, spec_error_o} <= 5'h00;
    end else begin
      done_o <= 1'b0;
      wr_o <= 1'b0;
      wr_pair_o <= 1'b0;
      {fx_overflow_o, divide_check_o, exp_overflow_o, exp_underflow_o, spec_error_o} <= 5'h00;
      if (state == dlwu_pkg::DLWU_ST_IDLE && start_i) begin
        if (kind == dlwu_pkg::DLWU_K_LOGIC) begin
          done_o <= 1'b1;
          wr_o <= 1'b1;
          res_o <= logic_res;
          if (logic_res == 32'h0000_0000) begin
            {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o} <= `DLWU_CODE_EQUAL;
          end else if (logic_res == 32'hFFFF_FFFF) begin
            {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o} <= `DLWU_CODE_GREATER;
          end else begin
            {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o} <= `DLWU_CODE_LESS;
          end
        end else if (kind == dlwu_pkg::DLWU_K_FDIV && fdbl && reg_sel_i[0]) begin
          // odd pair select refused, nothing written
          done_o <= 1'b1;
          spec_error_o <= 1'b1;
        end else if (kind == dlwu_pkg::DLWU_K_NONE) begin
          done_o <= 1'b1;
        end
      end else if (state == dlwu_pkg::DLWU_ST_DIV && div_done) begin
        done_o <= 1'b1;
        wr_o <= 1'b1;
        case (kind_q)
          dlwu_pkg::DLWU_K_HDIV: begin
            // halfword overflow, check and left-half code
            res_o <= {qs[15:0], keep_lo_q};
            fx_overflow_o <= q_ovf;
            divide_check_o <= dvs_zero_q;
            {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o}
              <= arith_code(qs[15:0] != 16'h0000, qs[15]);
          end
          dlwu_pkg::DLWU_K_FDIV: begin
            res_o <= fres[63:32];
            res_pair_o <= fres[31:0];
            wr_pair_o <= dbl_q;
            exp_overflow_o <= f_ovf;
            exp_underflow_o <= f_unf;
            divide_check_o <= dvs_zero_q;
            {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o}
              <= arith_code(fres != 64'h0, fres[63]);
          end
          default: begin
            // partner register keeps the low dividend word
            // result written even on overflow or check
            res_o <= qs[31:0];
            fx_overflow_o <= !odd_q && q_ovf;
            divide_check_o <= dvs_zero_q;
            {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o}
              <= arith_code(qs[31:0] != 32'h0000_0000, qs[31]);
          end
        endcase
      end
    end
  end
endmodule : dlwu_unit

// >>> sim/dlwu_fetch_model.sv
`timescale 1ns/1ps
module dlwu_fetch_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic busy_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic wr_i,
  input wire logic wr_pair_i,
  input wire logic [31:0] res_i,
  input wire logic [31:0] res_pair_i,
  output logic [31:0] reg_val_o,
  output logic [31:0] pair_val_o
);
  logic [31:0] regs [16];
  logic [3:0] sel_q;
  assign reg_val_o = regs[reg_sel_i];
  assign pair_val_o = regs[reg_sel_i | 4'h1];
  // plain always: the bench preloads regs between operations
  always @(posedge clk_i) begin
    if (start_i && !busy_i) begin
      sel_q <= reg_sel_i;
    end
    if (wr_i) begin
      regs[sel_q] <= res_i;
    end
    if (wr_pair_i) begin
      regs[sel_q | 4'h1] <= res_pair_i;
    end
  end
endmodule : dlwu_fetch_model

// >>> sim/dlwu_unit_checker.sv
`timescale 1ns/1ps
module dlwu_unit_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [7:0] op_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic [31:0] reg_val_i,
  input wire logic [63:0] operand_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic wr_o,
  input wire logic wr_pair_o,
  input wire logic [31:0] res_o,
  input wire logic result_less_flag_o,
  input wire logic result_greater_flag_o,
  input wire logic outcome_equal_flag_o,
  input wire logic fx_overflow_o,
  input wire logic divide_check_o,
  input wire logic exp_overflow_o,
  input wire logic exp_underflow_o,
  input wire logic spec_error_o
);
  logic [7:0] op_q;
  logic [31:0] rv_q;
  logic [31:0] od_q;
  logic blk;
  logic acc;
  logic in_div;
  logic q_div;
  logic [2:0] fl;
  logic [4:0] ex;
  logic [2:0] lg_code;
  logic [31:0] lg_exp;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  assign q_div = op_q[7:5] == 3'h3 && op_q[3:2] == 2'h1;
  // conservative: both cycles around a divide finish count as not idle
  assign acc = start_i && !busy_o && !(done_o && q_div) && !blk;
  assign in_div = op_i[7:5] == 3'h3 && op_i[3:2] == 2'h1 && !(op_i == 8'h67 && reg_sel_i[0]);
  assign fl = {result_less_flag_o, result_greater_flag_o, outcome_equal_flag_o};
  assign ex = {fx_overflow_o, divide_check_o, exp_overflow_o, exp_underflow_o, spec_error_o};
  assign lg_code = (res_o == 32'h0) ? 3'h1 : (&res_o) ? 3'h2 : 3'h4;
  always_comb begin
    case (op_q[3:2])
      2'h0: lg_exp = rv_q & od_q;
      2'h1: lg_exp = rv_q | od_q;
      default: lg_exp = rv_q ^ od_q;
    endcase
  end
  always_ff @(posedge clk_i) begin
    blk <= rst_b_i && done_o && q_div;
    if (acc) begin
      op_q <= op_i;
      rv_q <= reg_val_i;
      od_q <= operand_i[31:0];
    end
  end
  a_logic_answer: assert property (acc && op_i[7:5] == 3'h7
    |=> done_o && wr_o && !wr_pair_o && ex == 5'h00) else $error("logic answer wrong");
  a_div_latency: assert property (acc && in_div |-> ##130 done_o && wr_o)
    else $error("divide answer not at 130");
  a_div_busy: assert property (acc && in_div |=> busy_o [*8])
    else $error("busy missing during divide");
  a_odd_double: assert property (acc && op_i == 8'h67 && reg_sel_i[0]
    |=> done_o && spec_error_o && !wr_o) else $error("odd double select not refused");
  a_pair_write: assert property (wr_pair_o |-> wr_o && op_q == 8'h67)
    else $error("pair written outside double divide");
  a_exc_done: assert property (ex != 5'h00 |-> done_o)
    else $error("exception without done");
  a_logic_value: assert property (done_o && op_q[7:4] == 4'hE |-> res_o == lg_exp)
    else $error("logic word result wrong");
  a_logic_code: assert property (done_o && op_q[7:5] == 3'h7 |-> fl == lg_code)
    else $error("logic result code wrong");
  a_word_code: assert property (done_o && wr_o && op_q[7:5] == 3'h3 && op_q[3:0] == 4'h4
    |-> fl == ((res_o == 32'h0) ? 3'h1 : res_o[31] ? 3'h4 : 3'h2)) else $error("word code wrong");
  a_half_low: assert property (done_o && wr_o && op_q[7:5] == 3'h3 && op_q[3:0] == 4'h5
    |-> res_o[15:0] == rv_q[15:0]) else $error("half divide low half lost");
  a_fzero_both: assert property (divide_check_o && op_q[7:1] == 7'h33 |-> exp_overflow_o)
    else $error("float zero divisor lacks overflow");
  a_code_hold: assert property (!done_o |-> $stable(fl))
    else $error("result code moved without done");
endmodule : dlwu_unit_checker
bind dlwu_unit dlwu_unit_checker i_chk (.clk_i, .rst_b_i, .start_i, .op_i, .reg_sel_i,
  .reg_val_i, .operand_i, .busy_o, .done_o, .wr_o, .wr_pair_o, .res_o, .result_less_flag_o,
  .result_greater_flag_o, .outcome_equal_flag_o, .fx_overflow_o, .divide_check_o,
  .exp_overflow_o, .exp_underflow_o, .spec_error_o);

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] sel;
    logic [31:0] rv;
    logic [31:0] pv;
    logic [31:0] od;
    logic [31:0] res;
    logic [2:0] fl;
    logic [4:0] ex;
    logic wr;
    logic chk;
  } dlwu_case_t;
  // divide table; results of overflow and zero divisor are left unchecked
  localparam dlwu_case_t CASES [15] = '{
    '{8'h74, 4'h2, 32'hFFFFFFFF, 32'hFFFFFF9C, 32'h7, 32'hFFFFFFF2, 3'h4, 5'h00, 1'h1, 1'h1},
    '{8'h74, 4'h3, 32'h3E8, 32'h0, 32'h7, 32'h8E, 3'h2, 5'h00, 1'h1, 1'h1},
    '{8'h64, 4'h4, 32'h0, 32'h5, 32'h9, 32'h0, 3'h1, 5'h00, 1'h1, 1'h1},
    '{8'h74, 4'h6, 32'h1, 32'h0, 32'h1, 32'h0, 3'h0, 5'h10, 1'h1, 1'h0},
    '{8'h74, 4'h8, 32'h0, 32'h5, 32'h0, 32'h0, 3'h0, 5'h18, 1'h1, 1'h0},
    '{8'h74, 4'h9, 32'h5, 32'h0, 32'h0, 32'h0, 3'h0, 5'h08, 1'h1, 1'h0},
    '{8'h65, 4'h1, 32'hFFFFFF00, 32'h0, 32'h10, 32'hFFF0FF00, 3'h4, 5'h00, 1'h1, 1'h1},
    '{8'h75, 4'h5, 32'h12345, 32'h0, 32'h3, 32'h61172345, 3'h2, 5'h00, 1'h1, 1'h1},
    '{8'h75, 4'h7, 32'h100000, 32'h0, 32'h1, 32'h0, 3'h0, 5'h10, 1'h1, 1'h0},
    '{8'h66, 4'h2, 32'h12345678, 32'h0, 32'h0, 32'h0, 3'h0, 5'h0C, 1'h1, 1'h0},
    '{8'h67, 4'h3, 32'h12345678, 32'h0, 32'h0, 32'h0, 3'h0, 5'h01, 1'h0, 1'h0},
    '{8'h67, 4'h4, 32'h12345678, 32'h9ABCDEF0, 32'h0, 32'h0, 3'h0, 5'h0C, 1'h1, 1'h0},
    '{8'h66, 4'h1, 32'h41800000, 32'h0, 32'h41800000, 32'h41800000, 3'h2, 5'h00, 1'h1, 1'h1},
    '{8'h67, 4'h6, 32'h41800000, 32'h1, 32'h41800000, 32'h41800000, 3'h2, 5'h00, 1'h1, 1'h1},
    '{8'h00, 4'h2, 32'h0, 32'h0, 32'h0, 32'h0, 3'h0, 5'h00, 1'h0, 1'h0}};
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic start_i = 1'h0;
  logic [7:0] op_i = 8'h00;
  logic [3:0] reg_sel_i = 4'h0;
  logic [63:0] operand_i = 64'h0;
  logic [3:0] m_field_i = 4'h0;
  logic [11:0] n_field_i = 12'h000;
  logic [3:0] index_field_i = 4'h0;
  logic [31:0] index_val_i = 32'h0;
  logic [31:0] reg_val, pair_val, res_o, res_pair_o, r, imm, b;
  logic busy_o, done_o, wr_o, wr_pair_o;
  logic [2:0] fl;
  logic [4:0] ex;
  logic [7:0] lg_ops [6] = '{8'hE0, 8'hE4, 8'hE8, 8'hF0, 8'hF4, 8'hF8};
  logic [31:0] seed = 32'h2;
  int error_cnt = 0;
  int compares = 0;
  dlwu_case_t expq [$];
  dlwu_case_t e;
  dlwu_case_t c;
  dlwu_unit i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i),
    .reg_sel_i(reg_sel_i), .reg_val_i(reg_val), .reg_pair_val_i(pair_val), .operand_i(operand_i),
    .m_field_i(m_field_i), .n_field_i(n_field_i), .index_field_i(index_field_i),
    .index_val_i(index_val_i), .busy_o(busy_o), .done_o(done_o), .wr_o(wr_o),
    .wr_pair_o(wr_pair_o), .res_o(res_o), .res_pair_o(res_pair_o), .result_less_flag_o(fl[2]),
    .result_greater_flag_o(fl[1]), .outcome_equal_flag_o(fl[0]), .fx_overflow_o(ex[4]),
    .divide_check_o(ex[3]), .exp_overflow_o(ex[2]), .exp_underflow_o(ex[1]),
    .spec_error_o(ex[0]));
  dlwu_fetch_model i_fetch (.clk_i(clk_i), .start_i(start_i), .busy_i(busy_o),
    .reg_sel_i(reg_sel_i), .wr_i(wr_o), .wr_pair_i(wr_pair_o), .res_i(res_o),
    .res_pair_i(res_pair_o), .reg_val_o(reg_val), .pair_val_o(pair_val));
  always #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // leaves start high so logic operations can go back to back
  task automatic go(input dlwu_case_t t);
    i_fetch.regs[t.sel | 4'h1] = t.pv;
    i_fetch.regs[t.sel] = t.rv;
    op_i = t.op;
    reg_sel_i = t.sel;
    // double divisor keeps a zero low word so that one is exactly one
    operand_i = {t.od, (t.op == 8'h67) ? 32'h0 : t.od};
    start_i = 1'h1;
    expq.push_back(t);
    @(negedge clk_i);
  endtask : go
  // a stray logic request during busy must be ignored
  task automatic dv(input dlwu_case_t t);
    int k;
    go(t);
    op_i = 8'hE0;
    for (k = 0; k < 200 && done_o !== 1'h1; k++) begin
      start_i = (k == 3);
      @(negedge clk_i);
    end
    start_i = 1'h0;
    if (k == 200) begin
      check("done wait", 32'h0, 32'h1);
      stop_test();
    end else begin
      repeat (2) @(negedge clk_i);
      if (t.op == 8'h74 && !t.sel[0]) begin
        check("pair kept", i_fetch.regs[t.sel | 4'h1], t.pv);
      end
    end
  endtask : dv
  always @(negedge clk_i) begin
    if (rst_b_i && done_o === 1'h1) begin
      if (expq.size() == 0) begin
        check("unexpected done", 32'h1, 32'h0);
      end else begin
        e = expq.pop_front();
        check("write", {31'h0, wr_o}, {31'h0, e.wr});
        check("exceptions", {27'h0, ex}, {27'h0, e.ex});
        if (e.chk) check("result", res_o, e.res);
        check("pair write", {31'h0, wr_pair_o}, {31'h0, e.op == 8'h67 && e.wr});
        // a divisor of one hands the low dividend word back unchanged
        if (e.chk && e.op == 8'h67) check("pair result", res_pair_o, e.pv);
        if (e.fl != 3'h0) check("code", {29'h0, fl}, {29'h0, e.fl});
      end
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) i_fetch.regs[i] = 32'h0;
    repeat (3) @(negedge clk_i);
    check("reset outputs", {20'h0, busy_o, done_o, wr_o, wr_pair_o, fl, ex}, 32'h0);
    rst_b_i = 1'h1;
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      m_field_i = r[3:0];
      n_field_i = r[15:4];
      index_field_i = (i < 12) ? 4'h0 : r[19:16];
      index_val_i = rnd();
      imm = {16'h0, m_field_i, n_field_i}
        + ((index_field_i != 4'h0) ? {8'h0, index_val_i[23:0]} : 32'h0);
      c.op = lg_ops[i % 6];
      c.sel = r[23:20];
      c.pv = 32'h0;
      c.rv = rnd();
      c.od = (i < 6) ? {32{i[0]}} : rnd();
      b = c.op[4] ? imm : c.od;
      c.res = (c.op[3:2] == 2'h0) ? (c.rv & b) : (c.op[3:2] == 2'h1) ? (c.rv | b) : (c.rv ^ b);
      c.fl = (c.res == 32'h0) ? 3'h1 : (&c.res) ? 3'h2 : 3'h4;
      c.ex = 5'h00;
      c.wr = 1'h1;
      c.chk = 1'h1;
      go(c);
    end
    start_i = 1'h0;
    @(negedge clk_i);
    for (int i = 0; i < 15; i++) dv(CASES[i]);
    repeat (4) @(negedge clk_i);
    check("pending", expq.size(), 32'h0);
    stop_test();
  end
endmodule : tb_top
